// File: include/rtc_bus_pkg.sv
// Constants shared by the multiplexed host port of the clock-plus-RAM block.
// Assumes a single core clock; the bus offsets, register fields and divider counts live here.
package rtc_bus_pkg;
    // ----------------------------------------------------------------
    // AHB-Lite register offsets (byte addresses) and event bits
    // ----------------------------------------------------------------
    localparam logic [7:0] AHB_STATUS = 8'h00;
    localparam logic [7:0] AHB_MASK = 8'h04;
    localparam logic [7:0] AHB_INFO = 8'h08;
    localparam int EV_WRITE = 0;
    localparam int EV_READ = 1;
    localparam int EV_VALID = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] STATUS_RESET = 3'h0;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
    // ----------------------------------------------------------------
    // Location map seen on the muxed bus and control register fields
    // ----------------------------------------------------------------
    localparam int LOC_AW = 6;
    localparam logic [5:0] LOC_CTRL_A = 6'h0a;
    localparam logic [5:0] LOC_CTRL_B = 6'h0b;
    localparam logic [5:0] LOC_CTRL_C = 6'h0c;
    localparam logic [5:0] LOC_CTRL_D = 6'h0d;
    localparam int A_RATE_LSB = 0;
    localparam int A_RATE_W = 4;
    localparam int A_BASE_LSB = 4;
    localparam int A_BASE_W = 3;
    localparam int B_SQW_EN = 3;
    localparam int D_VALID = 7;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    // ----------------------------------------------------------------
    // Time base selection and dividers
    // ----------------------------------------------------------------
    localparam logic [2:0] BASE_4M = 3'h0;
    localparam logic [2:0] BASE_1M = 3'h1;
    localparam logic [2:0] BASE_32K = 3'h2;
    localparam logic [4:0] TAP_OFS_4M = 5'h07;
    localparam logic [4:0] TAP_OFS_1M = 5'h05;
    localparam logic [4:0] TAP_OFS_32K = 5'h00;
    localparam logic [3:0] RATE_LOW_LIMIT = 4'h3;
    localparam logic [4:0] TAP_LOW_ADD = 5'h05;
    localparam logic [4:0] TAP_HIGH_SUB = 5'h02;
    localparam int DIV_STAGES = 22;
    localparam int SQW_TAPS = 15;
    localparam int CLOCK_OUTPUT_PIN_DIV = 4;
    localparam int SYNC_STAGES = 2;
endpackage

// File: sim/mux_cpu_model.sv
// Processor model for the multiplexed host port: one bus cycle per call.
// Assumes the bench resolves the bus wire from this model and the device.
`timescale 1ns/1ns
`default_nettype none
module mux_cpu_model (
    input wire logic clk,
    input wire logic [7:0] bus_lvl,
    input wire logic dev_oe,
    output logic as_o,
    output logic ds_o,
    output logic rw_o,
    output logic ce_n,
    output logic [7:0] bus_o
);
    logic drv;
    logic [7:0] dat;
    logic [7:0] pat;

    // Idle levels; a released bus shows a pattern that changes every cycle.
    initial begin
        as_o = 1'b0;
        ds_o = 1'b0;
        rw_o = 1'b1;
        ce_n = 1'b1;
        drv = 1'b0;
        dat = 8'h00;
        pat = 8'h0f;
    end
    always @(posedge clk) begin
        if (!drv) pat <= pat + 8'h35;
    end
    assign bus_o = drv ? dat : pat;

    // Runs a read or a write in the chosen style; data strobes stand ten cycles, the address strobe six.
    task bus_cycle(input logic sty, input logic rd, input logic ce, input logic [5:0] loc,
                   input logic [7:0] wd, output logic [7:0] rdv, output logic seen);
        int i;
        seen = 1'b0;
        ce_n <= ce;
        ds_o <= sty;
        rw_o <= 1'b1;
        dat <= {2'b00, loc};
        drv <= 1'b1;
        as_o <= 1'b1;
        repeat (6) @(posedge clk);
        as_o <= 1'b0;
        repeat (4) @(posedge clk);
        drv <= !rd;
        dat <= wd;
        if (!sty) rw_o <= rd;
        repeat (2) @(posedge clk);
        if (!sty) ds_o <= 1'b1;
        else if (rd) ds_o <= 1'b0;
        else rw_o <= 1'b0;
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            seen = seen | dev_oe;
        end
        rdv = bus_lvl;
        ds_o <= sty;
        if (sty) rw_o <= 1'b1;
        // Write data and direction held past the trailing strobe edge.
        repeat (3) @(posedge clk);
        rw_o <= 1'b1;
        drv <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// File: sim/test_rtc_muxed_bus_interface.sv
// Self-checking bench for the multiplexed host port: AHB-Lite registers,
// bus cycles in both styles, clock output and square wave.
// Assumes mux_cpu_model and the rtc_bus_pkg constants.
`timescale 1ns/1ns
`default_nettype none
module test_rtc_muxed_bus_interface;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam logic [31:0] EW = 32'h1 << rtc_bus_pkg::EV_WRITE;
    localparam logic [31:0] ER = 32'h1 << rtc_bus_pkg::EV_READ;
    localparam logic [31:0] EV = 32'h1 << rtc_bus_pkg::EV_VALID;
    localparam logic [3:0] RATE [3] = '{4'h3, 4'h4, 4'h0};
    localparam int SQX [3] = '{32, 16, 0};
    localparam int CKX [3] = '{128, 32, 128};
    localparam logic [2:0] CF = 3'b101;
    localparam logic [7:0] SA = rtc_bus_pkg::AHB_STATUS, MA = rtc_bus_pkg::AHB_MASK;
    localparam logic [7:0] IA = rtc_bus_pkg::AHB_INFO;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clock_out_divider_select = 1'b1;
    logic psense = 1'b0;
    logic [3:0] tb_cnt = 4'h0;
    logic hsel = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, bus_oe, clock_output_pin, square_wave_out, irq, as_w, ds_w, rw_w, ce_w;
    logic [7:0] bus_out, cpu_bus, rv;
    logic seen, ck_d = 1'b0, sq_d = 1'b0;
    int err_count = 0, num_checks = 0, ck_n = 0, sq_n = 0, i, dc, dq;
    wire [7:0] bus_lvl = bus_oe ? bus_out : cpu_bus;

    rtc_muxed_bus_interface u_rtc_muxed_bus_interface (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .ADDRESS_STROBE(as_w),
        .DATA_STROBE(ds_w), .READ_WRITE(rw_w), .CHIP_ENABLE_N(ce_w),
        .MUXED_BUS_IN(bus_lvl), .MUXED_BUS_OUT(bus_out), .MUXED_BUS_OE(bus_oe),
        .TIMEBASE_INPUT(tb_cnt[3]), .CLOCK_OUT_DIVIDER_SELECT(clock_out_divider_select),
        .POWER_SENSE_IN(psense), .CLOCK_OUTPUT_PIN(clock_output_pin), .SQUARE_WAVE_OUT(square_wave_out),
        .IRQ(irq), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp));
    mux_cpu_model u_mux_cpu_model (.clk(core_clk), .bus_lvl(bus_lvl), .dev_oe(bus_oe),
        .as_o(as_w), .ds_o(ds_w), .rw_o(rw_w), .ce_n(ce_w), .bus_o(cpu_bus));

    // Clock, a time base of sixteen core cycles, and output edge counters.
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        tb_cnt <= tb_cnt + 4'h1;
        ck_d <= clock_output_pin;
        sq_d <= square_wave_out;
        if (clock_output_pin === 1'b1 && ck_d === 1'b0) ck_n++;
        if (square_wave_out === 1'b1 && sq_d === 1'b0) sq_n++;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task check(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Bounded wait for hready; running out ends the run.
    task wait_rdy;
        for (int k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (hreadyout === 1'b1) return;
        end
        err_count++;
        $display("unexpected hready expected 1 seen 0");
        test_done;
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        r = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(nm, x, e);
    endtask
    task cyc(input logic s, r, c, input logic [5:0] a, input logic [7:0] d);
        u_mux_cpu_model.bus_cycle(s, r, c, a, d, rv, seen);
    endtask
    task count(input int n);
        int c0, s0;
        c0 = ck_n;
        s0 = sq_n;
        repeat (n) @(posedge core_clk);
        dc = ck_n - c0;
        dq = sq_n - s0;
    endtask
    function automatic logic near(input int d, input int e);
        return (d >= e - (e > 0)) && (d <= e + (e > 0));
    endfunction

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        psense <= 1'b1;
        rdc("status reset", SA, 32'h0);
        rdc("mask reset", MA, 32'h0);
        rdc("info reset", IA, 32'h0);
        check("irq reset", {31'h0, irq}, 32'h0);
        // Direction style: write then read back one RAM location.
        cyc(1'b0, 1'b0, 1'b0, 6'h20, 8'ha5);
        check("oe in write", {31'h0, seen}, 32'h0);
        rdc("status write", SA, EW);
        cyc(1'b0, 1'b1, 1'b0, 6'h20, 8'h00);
        check("read data d", {24'h0, rv}, 32'ha5);
        check("oe in read", {31'h0, seen}, 32'h1);
        check("oe released", {31'h0, bus_oe}, 32'h0);
        rdc("info d", IA, 32'h20);
        rdc("status rw", SA, EW | ER);
        // Interrupt raised through the mask, then cleared by a one.
        wr(MA, ER);
        repeat (2) @(posedge core_clk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(SA, ER);
        repeat (2) @(posedge core_clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rdc("status w1c", SA, EW);
        wr(MA, 32'h0);
        // Separate-strobe style on another location.
        cyc(1'b1, 1'b0, 1'b0, 6'h21, 8'h3c);
        cyc(1'b1, 1'b1, 1'b0, 6'h21, 8'h00);
        check("read data s", {24'h0, rv}, 32'h3c);
        check("oe in read s", {31'h0, seen}, 32'h1);
        rdc("info s", IA, 32'h61);
        wr(SA, EW | ER);
        // Chip enable high: no write, no drive, no latch.
        cyc(1'b1, 1'b0, 1'b1, 6'h21, 8'hff);
        cyc(1'b0, 1'b1, 1'b1, 6'h20, 8'h00);
        check("oe ce high", {31'h0, seen}, 32'h0);
        rdc("status ce high", SA, 32'h0);
        rdc("info ce high", IA, 32'h61);
        cyc(1'b1, 1'b1, 1'b0, 6'h21, 8'h00);
        check("ce high no write", {24'h0, rv}, 32'h3c);
        // Valid flag: set by reading control D, cleared only by power sense low.
        cyc(1'b0, 1'b1, 1'b0, rtc_bus_pkg::LOC_CTRL_D, 8'h00);
        rdc("status valid", SA, ER | EV);
        rdc("info valid", IA, 32'h8d);
        psense <= 1'b0;
        repeat (6) @(posedge core_clk);
        psense <= 1'b1;
        repeat (6) @(posedge core_clk);
        rdc("info cleared", IA, 32'h0d);
        wr(8'h10, 32'hffffffff);
        rdc("unmapped", 8'h10, 32'h0);
        wr(IA, 32'hff);
        rdc("info read only", IA, 32'h0d);
        check("hresp", {31'h0, hresp}, 32'h0);
        // Clock output and square-wave taps on the slow time base.
        cyc(1'b0, 1'b0, 1'b0, rtc_bus_pkg::LOC_CTRL_B, 8'h01 << rtc_bus_pkg::B_SQW_EN);
        for (i = 0; i < 3; i++) begin
            clock_out_divider_select <= CF[i];
            cyc(1'b0, 1'b0, 1'b0, rtc_bus_pkg::LOC_CTRL_A, {1'b0, rtc_bus_pkg::BASE_32K, RATE[i]});
            count(2048);
            check("clock_output_pin rises", {31'h0, near(dc, CKX[i])}, 32'h1);
            check("sqw rises", {31'h0, near(dq, SQX[i])}, 32'h1);
        end
        cyc(1'b0, 1'b0, 1'b0, rtc_bus_pkg::LOC_CTRL_A, 8'h23);
        cyc(1'b0, 1'b0, 1'b0, rtc_bus_pkg::LOC_CTRL_B, 8'h00);
        count(1024);
        check("sqw disabled", dq, 32'h0);
        test_done;
    end

    // Run length limit.
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        $display("unexpected run length expected end seen limit");
        test_done;
    end
endmodule
`default_nettype wire

// File: verilog/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; only the second stage is read.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 8
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] PIN,
    output logic [W-1:0] LVL
);
    logic [W-1:0] meta_r;

    // ----------------------------------------------------------------
    // Synchroniser chain
    // ----------------------------------------------------------------
    // First stage feeds the second stage and nothing else.
    always_ff @(posedge CLK) begin
        if (RST) begin
            meta_r <= '0;
            LVL <= '0;
        end else begin
            meta_r <= PIN;
            LVL <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: verilog/rtc_muxed_bus_interface.sv
// Multiplexed address/data host port of a clock-plus-RAM device, with the
// clock output divider, square-wave source, valid-contents flag and an
// AHB-Lite slave for event status, event mask and port state.
// Assumes all pins but CORE_CLK, SYS_RST and the AHB-Lite port are asynchronous to CORE_CLK and much slower than it.
//
// How it works
// R1 - The data-strobe level caught at each address-strobe fall picks the bus style.
// R2 - In direction style, read is strobe with direction high and write is strobe with direction low.
// R3 - In separate-strobe style, read and write enables are the inverted low-true strobes.
// R4 - The six low bus lines are latched as the location at the address-strobe fall.
// R5 - A read drives eight bits late in the strobe and releases as the read strobe ends.
// R6 - In direction style, write data is taken at the falling edge of the data strobe.
// R7 - The processor holds write data stable through the latter part of the write strobe.
// R8 - The processor holds the data strobe low or high across the address strobe to pick the style.
// R9 - The processor holds direction high for a read and low for a write during the strobe.
// R10 - The clock output is the time base when the select pin is high and a quarter of it when low.
// R11 - Software picks the time base rate of 4.194304 MHz, 1.048576 MHz or 32.768 kHz in register A.
// R12 - The square wave is one of 15 taps of a 22-stage divider, switched by a bit of register B.
// R13 - The valid flag sets on a read of register D and clears only while power sense is low.
// R14 - With chip enable high no bus cycle acts and the bus output stays released.
// R15 - Strobes are synchronised to the core clock and edge-detected before they act.
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module rtc_muxed_bus_interface #(
    parameter int STAGES = rtc_bus_pkg::DIV_STAGES
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic ADDRESS_STROBE,
    input wire logic DATA_STROBE,
    input wire logic READ_WRITE,
    input wire logic CHIP_ENABLE_N,
    input wire logic [7:0] MUXED_BUS_IN,
    output logic [7:0] MUXED_BUS_OUT,
    output logic MUXED_BUS_OE,
    input wire logic TIMEBASE_INPUT,
    input wire logic CLOCK_OUT_DIVIDER_SELECT,
    input wire logic POWER_SENSE_IN,
    output logic CLOCK_OUTPUT_PIN,
    output logic SQUARE_WAVE_OUT,
    output logic IRQ,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);
    localparam int NSYNC = 15;

    logic [NSYNC-1:0] sync_lvl;
    logic astb_s, dstb_s, dir_s, cen_s, tb_s, clock_out_divider_select_s, ps_s;
    logic [7:0] ad_s;
    logic astb_q, tb_q;
    logic style_r;
    logic [5:0] addr_r;
    logic rd_en, wr_en, rd_en_q, wr_en_q, rd_end, wr_end, addr_fall, sel;
    logic [7:0] wdata_r, rd_data;
    logic [7:0] ctrl_a_r, ctrl_b_r;
    logic [7:0] mem [0:63];
    logic vrt_r;
    logic [1:0] ckdiv_r;
    logic [STAGES-1:0] div_r;
    logic [4:0] tap;
    logic [rtc_bus_pkg::EV_W-1:0] status_r, mask_r, events;
    logic ph_valid_r, ph_write_r;
    logic [7:0] ph_addr_r;
    logic addr_phase;

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    pin_sync #(.W(NSYNC)) u_sync (
        .CLK(CORE_CLK),
        .RST(SYS_RST),
        .PIN({ADDRESS_STROBE, DATA_STROBE, READ_WRITE, CHIP_ENABLE_N, MUXED_BUS_IN,
              TIMEBASE_INPUT, CLOCK_OUT_DIVIDER_SELECT, POWER_SENSE_IN}),
        .LVL(sync_lvl)
    );

    // Unpack the synchronised levels.
    assign {astb_s, dstb_s, dir_s, cen_s, ad_s, tb_s, clock_out_divider_select_s, ps_s} = sync_lvl; // R15

    // Previous strobe and time base levels for edge detection.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            astb_q <= 1'b0;
            tb_q <= 1'b0;
        end else begin
            astb_q <= astb_s;
            tb_q <= tb_s;
        end
    end

    // Address-strobe fall with the chip selected.
    assign addr_fall = astb_q & ~astb_s & ~cen_s; // R15 R14

    // ----------------------------------------------------------------
    // Bus style and address latch
    // ----------------------------------------------------------------
    // Style 0 is strobe plus direction, style 1 is separate strobes.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            style_r <= 1'b0;
            addr_r <= '0;
        end else if (addr_fall) begin
            style_r <= dstb_s; // R1
            addr_r <= ad_s[5:0]; // R4
        end
    end

    // No access while the address strobe stands, so a style change never drives the bus.
    assign sel = ~cen_s & ~astb_s & ~astb_q; // R14 R1

    // Internal enables formed per style.
    always_comb begin
        if (style_r) begin
            rd_en = sel & ~dstb_s; // R3
            wr_en = sel & ~dir_s; // R3
        end else begin
            rd_en = sel & dstb_s & dir_s; // R2
            wr_en = sel & dstb_s & ~dir_s; // R2
        end
    end

    // Enable history gives the trailing edge of each strobe.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rd_en_q <= 1'b0;
            wr_en_q <= 1'b0;
        end else begin
            rd_en_q <= rd_en;
            wr_en_q <= wr_en;
        end
    end

    assign rd_end = rd_en_q & ~rd_en;
    assign wr_end = wr_en_q & ~wr_en; // R6

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------
    // Track bus data while the write strobe stands; the last value wins.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            wdata_r <= '0;
        end else if (wr_en) begin
            wdata_r <= ad_s; // R7
        end
    end

    // Control registers A and B take the data at the strobe's trailing edge.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ctrl_a_r <= rtc_bus_pkg::CTRL_A_RESET;
            ctrl_b_r <= rtc_bus_pkg::CTRL_B_RESET;
        end else if (wr_end) begin
            if (addr_r == rtc_bus_pkg::LOC_CTRL_A) begin
                ctrl_a_r <= {1'b0, wdata_r[6:0]}; // R11
            end
            if (addr_r == rtc_bus_pkg::LOC_CTRL_B) begin
                ctrl_b_r <= wdata_r; // R6
            end
        end
    end

    // Plain locations hold whatever was written; they have no reset.
    always_ff @(posedge CORE_CLK) begin
        if (wr_end) begin
            mem[addr_r] <= wdata_r; // R6
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Register C and D are read only; bit 7 of register A reads zero.
    always_comb begin
        case (addr_r)
            rtc_bus_pkg::LOC_CTRL_A: rd_data = ctrl_a_r;
            rtc_bus_pkg::LOC_CTRL_B: rd_data = ctrl_b_r;
            rtc_bus_pkg::LOC_CTRL_C: rd_data = 8'h00;
            rtc_bus_pkg::LOC_CTRL_D: rd_data = {vrt_r, 7'h00};
            default: rd_data = mem[addr_r];
        endcase
    end

    // Drive the bus while the read enable stands, release as it ends.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            MUXED_BUS_OE <= 1'b0;
            MUXED_BUS_OUT <= 8'h00;
        end else begin
            MUXED_BUS_OE <= rd_en; // R5 R14
            MUXED_BUS_OUT <= rd_en ? rd_data : 8'h00; // R5
        end
    end

    // Valid flag: power sense low holds it clear, a read of D sets it.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            vrt_r <= 1'b0;
        end else if (!ps_s) begin
            vrt_r <= 1'b0; // R13
        end else if (rd_end && addr_r == rtc_bus_pkg::LOC_CTRL_D) begin
            vrt_r <= 1'b1; // R13
        end
    end

    // ----------------------------------------------------------------
    // Clock output and square wave
    // ----------------------------------------------------------------
    // Tap index from the time base select and rate fields.
    function automatic logic [4:0] tap_of(input logic [7:0] a);
        logic [3:0] rate;
        logic [4:0] ofs;
        rate = a[rtc_bus_pkg::A_RATE_LSB +: rtc_bus_pkg::A_RATE_W];
        case (a[rtc_bus_pkg::A_BASE_LSB +: rtc_bus_pkg::A_BASE_W])
            rtc_bus_pkg::BASE_4M: ofs = rtc_bus_pkg::TAP_OFS_4M;
            rtc_bus_pkg::BASE_1M: ofs = rtc_bus_pkg::TAP_OFS_1M;
            rtc_bus_pkg::BASE_32K: ofs = rtc_bus_pkg::TAP_OFS_32K;
            default: ofs = rtc_bus_pkg::TAP_OFS_32K;
        endcase
        if (rate < rtc_bus_pkg::RATE_LOW_LIMIT) begin
            tap_of = 5'(ofs + {1'b0, rate} + rtc_bus_pkg::TAP_LOW_ADD);
        end else begin
            tap_of = 5'(ofs + {1'b0, rate} - rtc_bus_pkg::TAP_HIGH_SUB);
        end
    endfunction

    assign tap = tap_of(ctrl_a_r); // R11

    // Divider chain and divide-by-four counter advance on time base rises.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ckdiv_r <= '0;
            div_r <= '0;
        end else if (!tb_q && tb_s) begin
            ckdiv_r <= ckdiv_r + 2'h1; // R10
            div_r <= div_r + STAGES'(1); // R12
        end
    end

    // Clock output follows the time base or its quarter.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CLOCK_OUTPUT_PIN <= 1'b0;
        end else begin
            CLOCK_OUTPUT_PIN <= clock_out_divider_select_s ? tb_s : ckdiv_r[1]; // R10
        end
    end

    // Square wave: enable bit in B, rate 0 or an out-of-range tap is off.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            SQUARE_WAVE_OUT <= 1'b0;
        end else if (ctrl_b_r[rtc_bus_pkg::B_SQW_EN]
                     && ctrl_a_r[rtc_bus_pkg::A_RATE_LSB +: rtc_bus_pkg::A_RATE_W] != 4'h0
                     && int'(tap) < STAGES) begin
            SQUARE_WAVE_OUT <= div_r[tap]; // R12
        end else begin
            SQUARE_WAVE_OUT <= 1'b0; // R12
        end
    end

    // ----------------------------------------------------------------
    // Events, status, mask and interrupt
    // ----------------------------------------------------------------
    assign events = {ps_s & ~vrt_r & rd_end & (addr_r == rtc_bus_pkg::LOC_CTRL_D),
                     rd_end, wr_end};
    assign addr_phase = HSEL & HREADY & HTRANS[1];

    // Sticky status: a new event wins over a write-one clear.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            status_r <= rtc_bus_pkg::STATUS_RESET;
        end else if (ph_valid_r && ph_write_r && ph_addr_r == rtc_bus_pkg::AHB_STATUS) begin
            status_r <= (status_r & ~HWDATA[rtc_bus_pkg::EV_W-1:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    // Mask register.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mask_r <= rtc_bus_pkg::MASK_RESET;
        end else if (ph_valid_r && ph_write_r && ph_addr_r == rtc_bus_pkg::AHB_MASK) begin
            mask_r <= HWDATA[rtc_bus_pkg::EV_W-1:0];
        end
    end

    // Level interrupt while any unmasked status bit stands.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_r & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ----------------------------------------------------------------
    // Address phase capture.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r <= 8'h00;
        end else if (HREADY) begin
            ph_valid_r <= addr_phase;
            ph_write_r <= HWRITE;
            ph_addr_r <= HADDR[7:0];
        end
    end

    // Read data is prepared in the address phase; unmapped reads give zero.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_phase && !HWRITE) begin
            case (HADDR[7:0])
                rtc_bus_pkg::AHB_STATUS: HRDATA <= {29'h0, status_r};
                rtc_bus_pkg::AHB_MASK: HRDATA <= {29'h0, mask_r};
                rtc_bus_pkg::AHB_INFO: HRDATA <= {24'h0, vrt_r, style_r, addr_r};
                default: HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Ready and response stand constant after reset.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    style_latch_a: assert property (addr_fall |=> style_r == $past(dstb_s)) // R1
        else $error("bus style not taken from data strobe");
    direction_read_a: assert property (!style_r && sel && dstb_s && dir_s |=> MUXED_BUS_OE) // R2
        else $error("direction style read did not drive bus");
    strobe_read_a: assert property (style_r && sel && !dstb_s |=> MUXED_BUS_OE) // R3
        else $error("separate strobe read did not drive bus");
    addr_latch_a: assert property (addr_fall |=> addr_r == $past(ad_s[5:0])) // R4
        else $error("location address not latched");
    bus_release_a: assert property ($fell(rd_en) |=> !MUXED_BUS_OE ##1 !MUXED_BUS_OE || rd_en) // R5
        else $error("bus not released after read");
    write_capture_a: assert property (wr_end && addr_r == rtc_bus_pkg::LOC_CTRL_B
                                      |=> ctrl_b_r == $past(wdata_r)) // R6
        else $error("register B write lost");
    clock_out_a: assert property (clock_out_divider_select_s |=> CLOCK_OUTPUT_PIN == $past(tb_s)) // R10
        else $error("undivided clock output wrong");
    quarter_out_a: assert property (!clock_out_divider_select_s |=> CLOCK_OUTPUT_PIN == $past(ckdiv_r[1])) // R10
        else $error("divided clock output wrong");
    sqw_off_a: assert property (!ctrl_b_r[rtc_bus_pkg::B_SQW_EN] |=> !SQUARE_WAVE_OUT) // R12
        else $error("square wave on while disabled");
    valid_clear_a: assert property (!ps_s |=> !vrt_r) // R13
        else $error("valid flag not cleared by power sense");
    valid_set_a: assert property (ps_s && rd_end && addr_r == rtc_bus_pkg::LOC_CTRL_D
                                  |=> vrt_r) // R13
        else $error("valid flag not set by register D read");
    chip_idle_a: assert property (cen_s [*2] |=> !MUXED_BUS_OE) // R14
        else $error("bus driven while deselected");
endmodule
`default_nettype wire
